// ### inc/ppm_pkg.sv
// ppm_pkg: register map, field positions, reset values and carriers for the
// pulse period measurement timer. assumes an APB slave with 32-bit data.
package ppm_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] IOC_OFS = 8'h04;
   localparam logic [7:0] MODE_OFS = 8'h08;
   localparam logic [7:0] PRE_OFS = 8'h0C;
   localparam logic [7:0] CNT_OFS = 8'h10;
   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_ACT_BIT = 1;
   localparam int CTRL_HALT_BIT = 2;
   localparam int CTRL_EDGF_BIT = 4;
   localparam int CTRL_UNDF_BIT = 5;
   // ----------------------------------------
   // io control fields
   // ----------------------------------------
   localparam int IOC_EDGE_BIT = 0;
   localparam int IOC_PIN_BIT = 2;
   localparam int IOC_FLT_LO_BIT = 4;
   localparam int IOC_FLT_HI_BIT = 5;
   // clock select field in the mode register, bits 6:4
   localparam int MODE_CKS_LSB = 4;
   // ----------------------------------------
   // reset values and counts
   // ----------------------------------------
   localparam logic [7:0] PRE_RST = 8'hFF;
   localparam logic [7:0] CNT_RST = 8'hFF;
   localparam logic [2:0] CKS_RST = 3'h0;
   localparam int FILTER_TAPS = 3;
   // ----------------------------------------
   // count clock choices
   // ----------------------------------------
   typedef enum logic [2:0] {
      CKS_DIV1 = 3'h0,
      CKS_DIV8 = 3'h1,
      CKS_OSC = 3'h2,
      CKS_DIV2 = 3'h3,
      CKS_SUB32 = 3'h4
   } ppm_cks_t;
   // ----------------------------------------
   // software configuration carrier
   // ----------------------------------------
   typedef struct packed {
      logic edge_period_select;
      logic input_pin_select;
      logic filter_ctrl_low;
      logic filter_ctrl_high;
      ppm_cks_t clk_sel;
   } ppm_cfg_t;
endpackage : ppm_pkg

// ### rtl/ppm_timer.sv
// ppm_timer: 8-bit prescaler and 8-bit down counter in pulse period
// measurement mode, with an APB register slave.
// assumes clock-tick inputs already synchronous to clk_i, one cycle wide.
//
// Summary of operation
// RULE1: count clock chosen from div1, div2, div8, oscillator or subclock div32.
// RULE2: count down; capture count into read-out buffer at first underflow after edge.
// RULE3: second prescaler underflow after edge reloads main counter and counting goes on.
// RULE4: writing 1 to count_run_request starts counting.
// RULE5: writing 0 to count_run_request, or 1 to forced_halt, stops counting.
// RULE6: interrupt request on main counter underflow or reload.
// RULE7: interrupt request on the selected active edge of the input.
// RULE8: reading main count register returns the read-out buffer.
// RULE9: write while stopped loads both reload register and counter.
// RULE10: write while running still loads both reload register and counter.
// RULE11: edge_period_select 0 measures rising to rising, 1 falling to falling.
// RULE12: input_pin_select chooses between two input pins.
// RULE13: filter_ctrl bits enable the digital filter and choose its sample rate.
// RULE14: source keeps the period above twice the prescaler underflow period.
// RULE15: source keeps high and low phases above one prescaler period.
// RULE16: active_edge_flag sets at second prescaler underflow after an active edge.
// RULE17: buffer held until main count register is read.
// RULE18: unread buffer is not overwritten by a later measurement.
// RULE19: clear edge flag by writing 0 to it and 1 to underflow flag.
// RULE20: clear underflow flag by writing 0 to it and 1 to edge flag.
// RULE21: underflow-reload coinciding with edge sets both flags.
// RULE22: writing 0 clears a flag, writing 1 leaves it unchanged.
// RULE23: software clears both flags before starting after a mode change.
// RULE24: software waits two prescaler periods after start before clearing edge flag.
// RULE25: underflow flag sets on underflow or reload; flags stay until cleared.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module ppm_timer #(
   parameter int CNT_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic tick_div2_i,
   input wire logic tick_div8_i,
   input wire logic tick_osc_i,
   input wire logic tick_sub32_i,
   input wire logic measured_input_pin_a_i,
   input wire logic measured_input_pin_b_i,
   output logic irq_o
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   always_comb begin
      addr_ok = (paddr_i == ppm_pkg::CTRL_OFS) || (paddr_i == ppm_pkg::IOC_OFS) ||
                (paddr_i == ppm_pkg::MODE_OFS) || (paddr_i == ppm_pkg::PRE_OFS) ||
                (paddr_i == ppm_pkg::CNT_OFS);
      wr_en = psel_i && penable_i && pwrite_i && addr_ok && pstrb_i[0];
      rd_en = psel_i && penable_i && !pwrite_i && addr_ok;
   end
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;

   function automatic logic wr_hit(input logic [7:0] ofs);
      return wr_en && (paddr_i == ofs);
   endfunction : wr_hit

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   ppm_pkg::ppm_cfg_t cfg_reg;
   logic run_reg;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg <= '{1'b0, 1'b0, 1'b0, 1'b0, ppm_pkg::ppm_cks_t'(ppm_pkg::CKS_RST)};
      end else begin
         if (wr_hit(ppm_pkg::IOC_OFS)) begin
            // RULE11 edge choice stored
            cfg_reg.edge_period_select <= pwdata_i[ppm_pkg::IOC_EDGE_BIT];
            cfg_reg.input_pin_select <= pwdata_i[ppm_pkg::IOC_PIN_BIT];
            cfg_reg.filter_ctrl_low <= pwdata_i[ppm_pkg::IOC_FLT_LO_BIT];
            cfg_reg.filter_ctrl_high <= pwdata_i[ppm_pkg::IOC_FLT_HI_BIT];
         end
         if (wr_hit(ppm_pkg::MODE_OFS)) begin
            cfg_reg.clk_sel <= ppm_pkg::ppm_cks_t'(pwdata_i[ppm_pkg::MODE_CKS_LSB +: 3]);
         end
      end
   end

   // RULE4 start and RULE5 stop or forced halt
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_reg <= 1'b0;
      end else if (wr_hit(ppm_pkg::CTRL_OFS)) begin
         run_reg <= pwdata_i[ppm_pkg::CTRL_RUN_BIT] && !pwdata_i[ppm_pkg::CTRL_HALT_BIT];
      end
   end

   // ----------------------------------------
   // count clock select
   // ----------------------------------------
   logic src_tick;
   // RULE1 count clock mux; unlisted codes never tick
   always_comb begin
      unique case (cfg_reg.clk_sel)
         ppm_pkg::CKS_DIV1: src_tick = 1'b1;
         ppm_pkg::CKS_DIV2: src_tick = tick_div2_i;
         ppm_pkg::CKS_DIV8: src_tick = tick_div8_i;
         ppm_pkg::CKS_OSC: src_tick = tick_osc_i;
         ppm_pkg::CKS_SUB32: src_tick = tick_sub32_i;
         default: src_tick = 1'b0;
      endcase
   end
   logic cnt_tick;
   assign cnt_tick = run_reg && src_tick;

   // ----------------------------------------
   // input select, filter and edge detect
   // ----------------------------------------
   logic pin_raw;
   // RULE12 pin choice
   assign pin_raw = cfg_reg.input_pin_select ? measured_input_pin_b_i : measured_input_pin_a_i;
   logic [ppm_pkg::FILTER_TAPS-1:0] flt_sh_reg;
   logic flt_out_reg;
   logic flt_sample;
   logic pin_prev_reg;
   // RULE13 filter off when both bits low; otherwise sample rate by the high bit
   always_comb begin
      if (cfg_reg.filter_ctrl_high) begin
         flt_sample = tick_div8_i;
      end else begin
         flt_sample = cfg_reg.filter_ctrl_low;
      end
   end
   logic flt_en;
   assign flt_en = cfg_reg.filter_ctrl_low || cfg_reg.filter_ctrl_high;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flt_sh_reg <= '0;
         flt_out_reg <= 1'b0;
      end else if (!flt_en) begin
         flt_sh_reg <= {ppm_pkg::FILTER_TAPS{pin_raw}};
         flt_out_reg <= pin_raw;
      end else if (flt_sample) begin
         flt_sh_reg <= {flt_sh_reg[ppm_pkg::FILTER_TAPS-2:0], pin_raw};
         // level passes only once all taps agree
         if (&flt_sh_reg) begin
            flt_out_reg <= 1'b1;
         end else if (~|flt_sh_reg) begin
            flt_out_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_prev_reg <= 1'b0;
      end else begin
         pin_prev_reg <= flt_out_reg;
      end
   end
   logic active_edge;
   // RULE11 rising edges when select is 0, falling when 1
   assign active_edge = run_reg && (cfg_reg.edge_period_select ?
                        (pin_prev_reg && !flt_out_reg) : (!pin_prev_reg && flt_out_reg));

   // ----------------------------------------
   // prescaler and main counter
   // ----------------------------------------
   logic [CNT_W-1:0] pre_rld_reg;
   logic [CNT_W-1:0] pre_cnt_reg;
   logic [CNT_W-1:0] cnt_rld_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic pre_unf;
   assign pre_unf = cnt_tick && (pre_cnt_reg == '0);
   // edge tracker: 0 idle, 1 edge seen, 2 first underflow done
   logic [1:0] edge_stage_reg;
   logic capture;
   logic reload_evt;
   logic main_unf;
   // RULE2 capture at first underflow after edge
   assign capture = pre_unf && (edge_stage_reg == 2'd1);
   // RULE3 reload at second underflow after edge
   assign reload_evt = pre_unf && (edge_stage_reg == 2'd2);
   assign main_unf = pre_unf && (cnt_reg == '0) && !reload_evt;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_stage_reg <= 2'd0;
      end else if (!run_reg) begin
         edge_stage_reg <= 2'd0;
      end else if (active_edge && edge_stage_reg == 2'd0) begin
         edge_stage_reg <= 2'd1;
      end else if (capture) begin
         edge_stage_reg <= 2'd2;
      end else if (reload_evt) begin
         edge_stage_reg <= active_edge ? 2'd1 : 2'd0;
      end
   end

   // RULE9 and RULE10 writes land in reload register and counter, stopped or running
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_rld_reg <= CNT_W'(ppm_pkg::PRE_RST);
         pre_cnt_reg <= CNT_W'(ppm_pkg::PRE_RST);
      end else if (wr_hit(ppm_pkg::PRE_OFS)) begin
         pre_rld_reg <= pwdata_i[CNT_W-1:0];
         pre_cnt_reg <= pwdata_i[CNT_W-1:0];
      end else if (pre_unf) begin
         pre_cnt_reg <= pre_rld_reg;
      end else if (cnt_tick) begin
         pre_cnt_reg <= pre_cnt_reg - CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_rld_reg <= CNT_W'(ppm_pkg::CNT_RST);
         cnt_reg <= CNT_W'(ppm_pkg::CNT_RST);
      end else if (wr_hit(ppm_pkg::CNT_OFS)) begin
         // RULE10 running write also reaches counter
         cnt_rld_reg <= pwdata_i[CNT_W-1:0];
         cnt_reg <= pwdata_i[CNT_W-1:0];
      end else if (reload_evt || main_unf) begin
         // RULE3 reload and continue down
         cnt_reg <= cnt_rld_reg;
      end else if (pre_unf) begin
         cnt_reg <= cnt_reg - CNT_W'(1);
      end
   end

   // ----------------------------------------
   // read-out buffer
   // ----------------------------------------
   logic [CNT_W-1:0] rbuf_reg;
   logic rbuf_full_reg;
   logic cnt_read;
   assign cnt_read = rd_en && (paddr_i == ppm_pkg::CNT_OFS) &&
                     (prdata_o[CNT_W-1:0] == rbuf_reg);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rbuf_reg <= '0;
         rbuf_full_reg <= 1'b0;
      end else if (capture && !rbuf_full_reg) begin
         // RULE18 unread result is kept, new one dropped
         rbuf_reg <= cnt_reg;
         rbuf_full_reg <= 1'b1;
      end else if (cnt_read) begin
         // RULE17 held until software reads it
         rbuf_full_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // flags: set wins over clear
   // ----------------------------------------
   logic edgf_reg;
   logic undf_reg;
   logic ctrl_wr;
   assign ctrl_wr = wr_hit(ppm_pkg::CTRL_OFS);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edgf_reg <= 1'b0;
         undf_reg <= 1'b0;
      end else begin
         // RULE16 and RULE21 edge flag at second underflow
         if (reload_evt) begin
            edgf_reg <= 1'b1;
         // RULE22 zero clears, one keeps
         end else if (ctrl_wr && !pwdata_i[ppm_pkg::CTRL_EDGF_BIT]) begin
            edgf_reg <= 1'b0;
         end
         // RULE25 and RULE21 underflow flag on underflow or reload
         if (reload_evt || main_unf) begin
            undf_reg <= 1'b1;
         end else if (ctrl_wr && !pwdata_i[ppm_pkg::CTRL_UNDF_BIT]) begin
            undf_reg <= 1'b0;
         end
      end
   end

   // RULE6 and RULE7 interrupt pulse on underflow, reload or active edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= main_unf || reload_evt || active_edge;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (paddr_i)
         ppm_pkg::CTRL_OFS: begin
            rd_next[ppm_pkg::CTRL_RUN_BIT] = run_reg;
            rd_next[ppm_pkg::CTRL_ACT_BIT] = run_reg;
            rd_next[ppm_pkg::CTRL_EDGF_BIT] = edgf_reg;
            rd_next[ppm_pkg::CTRL_UNDF_BIT] = undf_reg;
         end
         ppm_pkg::IOC_OFS: begin
            rd_next[ppm_pkg::IOC_EDGE_BIT] = cfg_reg.edge_period_select;
            rd_next[ppm_pkg::IOC_PIN_BIT] = cfg_reg.input_pin_select;
            rd_next[ppm_pkg::IOC_FLT_LO_BIT] = cfg_reg.filter_ctrl_low;
            rd_next[ppm_pkg::IOC_FLT_HI_BIT] = cfg_reg.filter_ctrl_high;
         end
         ppm_pkg::MODE_OFS: rd_next[ppm_pkg::MODE_CKS_LSB +: 3] = cfg_reg.clk_sel;
         ppm_pkg::PRE_OFS: rd_next[CNT_W-1:0] = pre_cnt_reg;
         // RULE8 count reads return the buffer
         ppm_pkg::CNT_OFS: rd_next[CNT_W-1:0] = rbuf_reg;
         default: rd_next = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= rd_next;
      end
   end
endmodule : ppm_timer

// ### testbench/ppm_pulse_src.sv
// ppm_pulse_src: square wave source for the measured input pins.
// assumes half_i spans several prescaler periods.
`timescale 1ns/100ps
module ppm_pulse_src (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic sel_i,
   input wire logic [7:0] half_i,
   output logic pin_a_o,
   output logic pin_b_o
);
   logic lvl_reg;
   logic alt_reg;
   logic [7:0] cnt_reg;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl_reg <= 1'b0;
         alt_reg <= 1'b0;
         cnt_reg <= 8'h00;
      end else begin
         alt_reg <= !alt_reg;
         if (!run_i) begin
            cnt_reg <= 8'h00;
         end else if (cnt_reg >= half_i - 8'h01) begin
            cnt_reg <= 8'h00;
            lvl_reg <= !lvl_reg;
         end else begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
   // idle pin toggles every cycle so a wrong pin choice shows up
   assign pin_a_o = sel_i ? alt_reg : lvl_reg;
   assign pin_b_o = sel_i ? lvl_reg : alt_reg;
endmodule : ppm_pulse_src

// ### testbench/ppm_timer_props.sv
// ppm_timer_props: port-level checks for ppm_timer.
// assumes an apb master that keeps the setup and access order.
`timescale 1ns/100ps
module ppm_timer_props (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic irq_o
);
   // ------------------------
   // shadow of software state
   // ------------------------
   logic run_reg;
   logic pre_ok_reg;
   logic [7:0] pre_reg;
   logic [3:0] age_reg;
   wire logic acc = psel_i && penable_i;
   wire logic wr = acc && pwrite_i && pstrb_i[0];
   wire logic rs = psel_i && !penable_i && !pwrite_i;
   wire logic map = paddr_i inside {ppm_pkg::CTRL_OFS, ppm_pkg::IOC_OFS,
      ppm_pkg::MODE_OFS, ppm_pkg::PRE_OFS, ppm_pkg::CNT_OFS};
   // age gives a start or stop a few cycles to land
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_reg <= 1'b0;
         age_reg <= 4'hF;
      end else if (wr && paddr_i == ppm_pkg::CTRL_OFS) begin
         run_reg <= pwdata_i[0] && !pwdata_i[2];
         age_reg <= 4'h0;
      end else if (age_reg != 4'hF) begin
         age_reg <= age_reg + 4'h1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_reg <= ppm_pkg::PRE_RST;
         pre_ok_reg <= 1'b1;
      end else if (wr && paddr_i == ppm_pkg::PRE_OFS && !run_reg) begin
         pre_reg <= pwdata_i[7:0];
         pre_ok_reg <= 1'b1;
      end else if (run_reg) begin
         pre_ok_reg <= 1'b0;
      end
   end
   // ------------------------
   // assertions
   // ------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   run_status_a: assert property (rs && paddr_i == ppm_pkg::CTRL_OFS
      && age_reg > 4'h4 |=> prdata_o[1] == run_reg) else $error("status bit wrong");
   halt_reads_zero_a: assert property (rs && paddr_i == ppm_pkg::CTRL_OFS
      |=> !prdata_o[2]) else $error("halt bit read back");
   stopped_quiet_a: assert property (!run_reg && age_reg > 4'h4 |-> !irq_o)
      else $error("irq while stopped");
   stopped_load_a: assert property (rs && paddr_i == ppm_pkg::PRE_OFS && pre_ok_reg
      && age_reg > 4'h4 |=> prdata_o[7:0] == pre_reg) else $error("prescaler not loaded");
   upper_zero_a: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   unmapped_err_a: assert property (acc |-> pslverr_o == !map)
      else $error("slave error wrong");
   ready_high_a: assert property (acc |-> pready_o) else $error("not ready");
   reset_quiet_a: assert property (!$past(rst_n_i) |-> !irq_o && !pslverr_o)
      else $error("output active after reset");
endmodule : ppm_timer_props
bind ppm_timer ppm_timer_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .irq_o(irq_o));

// ### testbench/ppm_timer_bench.sv
// ppm_timer_bench: self-checking bench for ppm_timer over apb.
// assumes ppm_pkg, the pulse source and the checker are compiled first.
`timescale 1ns/100ps
module ppm_timer_bench;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [7:0] d;
      logic err;
   } ppm_row_t;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0] pstrb_i = 4'hF;
   logic t2 = 1'b0;
   logic t8 = 1'b0;
   logic tosc = 1'b0;
   logic t32 = 1'b0;
   logic src_run = 1'b0;
   logic src_sel = 1'b0;
   logic [7:0] src_half = 8'h14;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, irq_o, pin_a, pin_b, e;
   logic [7:0] q;
   int cyc = 0;
   int n;
   int err_count = 0;
   int tests_run = 0;
   logic [2:0] cks [6] = '{ppm_pkg::CKS_DIV1, ppm_pkg::CKS_DIV8, ppm_pkg::CKS_OSC,
      ppm_pkg::CKS_DIV2, ppm_pkg::CKS_SUB32, 3'h7};
   int dv [6] = '{1, 8, 3, 2, 32, 0};
   ppm_row_t rows [14] = '{'{1'b0, ppm_pkg::CTRL_OFS, 8'h00, 1'b0},
      '{1'b0, ppm_pkg::PRE_OFS, 8'hFF, 1'b0}, '{1'b0, ppm_pkg::MODE_OFS, 8'h00, 1'b0},
      '{1'b1, ppm_pkg::IOC_OFS, 8'h35, 1'b0}, '{1'b0, ppm_pkg::IOC_OFS, 8'h35, 1'b0},
      '{1'b1, ppm_pkg::MODE_OFS, 8'h40, 1'b0}, '{1'b0, ppm_pkg::MODE_OFS, 8'h40, 1'b0},
      '{1'b1, ppm_pkg::PRE_OFS, 8'h03, 1'b0}, '{1'b0, ppm_pkg::PRE_OFS, 8'h03, 1'b0},
      '{1'b1, ppm_pkg::CTRL_OFS, 8'h04, 1'b0}, '{1'b0, ppm_pkg::CTRL_OFS, 8'h00, 1'b0},
      '{1'b1, 8'h14, 8'h5A, 1'b1}, '{1'b0, 8'h14, 8'h00, 1'b1},
      '{1'b1, ppm_pkg::IOC_OFS, 8'h00, 1'b0}};
   ppm_timer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tick_div2_i(t2),
      .tick_div8_i(t8), .tick_osc_i(tosc), .tick_sub32_i(t32),
      .measured_input_pin_a_i(pin_a), .measured_input_pin_b_i(pin_b), .irq_o(irq_o));
   ppm_pulse_src src (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(src_run), .sel_i(src_sel),
      .half_i(src_half), .pin_a_o(pin_a), .pin_b_o(pin_b));
   always #4 clk_i = ~clk_i;
   // count clock enables; osc stands in at one tick in three
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      t2 <= cyc % 2 == 1;
      t8 <= cyc % 8 == 7;
      tosc <= cyc % 3 == 0;
      t32 <= cyc % 32 == 31;
   end
   task chk8(input logic [7:0] g, input logic [7:0] x);
      tests_run++;
      if (g !== x) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk8
   task chk1(input logic g, input logic x);
      chk8({7'h00, g}, {7'h00, x});
   endtask : chk1
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      q = prdata_o[7:0];
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task wbit(input int b);
      n = 0;
      do begin
         apb(1'b0, ppm_pkg::CTRL_OFS, 8'h00);
         n++;
      end while (q[b] !== 1'b1 && n < 400);
      chk1(q[b], 1'b1);
   endtask : wbit
   // stop, reconfigure, then measure one full period at div1, prescaler 1
   task measure(input logic [7:0] ioc);
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h00);
      apb(1'b1, ppm_pkg::MODE_OFS, 8'h00);
      apb(1'b1, ppm_pkg::IOC_OFS, ioc);
      apb(1'b1, ppm_pkg::PRE_OFS, 8'h01);
      apb(1'b1, ppm_pkg::CNT_OFS, 8'hFF);
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h01);
      src_run <= 1'b1;
      wbit(4);
      apb(1'b0, ppm_pkg::CNT_OFS, 8'h00);
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h21);
      apb(1'b0, ppm_pkg::CTRL_OFS, 8'h00);
      chk1(q[4], 1'b0);
      wbit(4);
      apb(1'b0, ppm_pkg::CNT_OFS, 8'h00);
      chk1(q >= 8'hE8 && q <= 8'hEE, 1'b1);
   endtask : measure
   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      #320000;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk1(e, rows[i].err);
         if (!rows[i].w) chk8(q, rows[i].d);
      end
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, ppm_pkg::MODE_OFS, {5'h00, cks[i]} << ppm_pkg::MODE_CKS_LSB);
         apb(1'b1, ppm_pkg::PRE_OFS, 8'h01);
         apb(1'b1, ppm_pkg::CNT_OFS, 8'h02);
         apb(1'b1, ppm_pkg::CTRL_OFS, 8'h01);
         n = 0;
         while (irq_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
         end
         chk1(n >= 4 * dv[i] && n <= 6 * dv[i] + 8, dv[i] != 0);
         apb(1'b1, ppm_pkg::CTRL_OFS, 8'h00);
      end
      measure(8'h00);
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h21);
      wbit(4);
      src_half <= 8'h1E;
      repeat (250) @(posedge clk_i);
      apb(1'b0, ppm_pkg::CNT_OFS, 8'h00);
      chk1(q >= 8'hE8 && q <= 8'hEE, 1'b1);
      src_half <= 8'h14;
      src_sel <= 1'b1;
      measure(8'h14);
      measure(8'h15);
      src_run <= 1'b0;
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h11);
      wbit(5);
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h11);
      apb(1'b0, ppm_pkg::CTRL_OFS, 8'h00);
      chk8(q & 8'h30, 8'h10);
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h05);
      repeat (4) @(posedge clk_i);
      apb(1'b0, ppm_pkg::CTRL_OFS, 8'h00);
      chk8(q, 8'h00);
      apb(1'b1, ppm_pkg::CTRL_OFS, 8'h01);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, ppm_pkg::CTRL_OFS, 8'h00);
      chk8(q, 8'h00);
      apb(1'b0, ppm_pkg::PRE_OFS, 8'h00);
      chk8(q, ppm_pkg::PRE_RST);
      end_of_test();
   end
endmodule : ppm_timer_bench
